// ===== src/tor_map.vh
// constants for the torque-off recovery block: register map, fields, reset values, timing
// assumes a 200 MHz system clock and a 32-bit APB register bus
`ifndef TOR_MAP_VH
`define TOR_MAP_VH

// register byte offsets
`define TOR_OFF_CTRL 12'h000
`define TOR_OFF_BLANK 12'h004
`define TOR_OFF_STATUS 12'h008
`define TOR_OFF_ALARM 12'h00c
`define TOR_OFF_IRQ_STAT 12'h010
`define TOR_OFF_IRQ_CLR 12'h014
`define TOR_OFF_IRQ_EN 12'h018

// control register fields
`define TOR_CTRL_MODE_BIT 0
`define TOR_CTRL_CRIT_LO 1
`define TOR_CTRL_CRIT_HI 2

// setting encodings and reset values
`define TOR_MODE_NO_ALARM 1'b0
`define TOR_MODE_ALARM 1'b1
`define TOR_CRIT_EDGE 2'h1
`define TOR_CRIT_LEVEL 2'h2
`define TOR_BLANK_RESET 7'h00
`define TOR_BLANK_MAX 7'h64
`define TOR_ALARM_CODE 8'h68
`define TOR_ALARM_NONE 8'h00

// status register bits
`define TOR_ST_INPUT_OFF 0
`define TOR_ST_TORQUE_OFF 1
`define TOR_ST_EXT_DEV 2
`define TOR_ST_EXCITED 3
`define TOR_ST_READY 4
`define TOR_ST_ALARM 5
`define TOR_ST_BLANKING 6
`define TOR_ST_REMOVED 7

// interrupt event bits
`define TOR_EV_INPUT_OFF 0
`define TOR_EV_REMOVED 1
`define TOR_EV_EXCITED 2
`define TOR_EV_ALARM 3
`define TOR_EV_W 4

// timing
`define TOR_CLK_PERIOD_NS 5
`define TOR_MS_NS 1000000
`define TOR_READY_DELAY_MS 4'h1
`define TOR_MS_CNT_W 18
`define TOR_SYNC_W 5

`endif

// ===== src/tor_sync.v
// two flip-flop synchroniser for a vector of independent level inputs
// assumes each bit is a slow level; no bit-to-bit coherence is kept
`timescale 1ns/1ps
module tor_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // asynchronous levels in, synchronised levels out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== src/tor_top.v
// torque-off recovery logic: monitors, clear gating with blanking, excitation and ready, apb registers
// assumes contacts and host command may be asynchronous; apb is on the same 200 MHz clock
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "tor_map.vh"

// Functional notes
// - With both channels back on, a clear while the host commands excitation excites the motor.
// - The clear criterion picks rising-edge (1, default) or on-level (2) action of the clear input.
// - The input-off monitor is high while either channel is off.
// - In alarm mode 0 the torque-off monitor is set when either channel turns off.
// - The torque-off monitor clears when the clear is accepted after both channels are back on.
// - Alarm mode selects no alarm (0, default) or an alarm (1) when either channel turns off.
// - The external-device monitor is high only while both channels are off.
// - The clear is ignored and no excitation happens until a 0 to 100 ms blanking time expires.
// - Blanking starts when both channels have turned on.
// - After blanking a qualified clear with command excites within 10 ms and readies within 60 ms.
// - In level mode the motor is excited while the clear is held on, not only at its edge.
// - Power removal with de-excitation follows both channels off within 15 ms.
// - In alarm mode 1 a channel turning off raises an alarm with code 68h.
module tor_top #(
  parameter MS_TICK_CYCLES = `TOR_MS_NS / `TOR_CLK_PERIOD_NS
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // shut-off contacts, high means on
  input wire shutoff_channel_upper,
  input wire shutoff_channel_lower,
  // recovery inputs
  input wire torque_off_clear_in,
  input wire alarm_clear_in,
  // host excitation command
  input wire excite_cmd,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // monitors and driver state
  output reg shutoff_input_off_monitor,
  output reg torque_off_state_monitor,
  output reg external_device_monitor,
  output reg motor_excite,
  output reg drive_ready,
  output reg power_removed,
  output reg alarm_active,
  output reg [7:0] alarm_code,
  output reg irq
);

  wire [`TOR_SYNC_W-1:0] sync_w;
  wire up_on, lo_on, clr_in, aclr_in, cmd_in;
  reg clr_prev_q, aclr_prev_q, both_on_prev_q;
  reg alarm_mode_q;
  reg [1:0] crit_q;
  reg [6:0] blank_ms_q;
  reg [6:0] blank_cnt_q;
  reg [`TOR_MS_CNT_W-1:0] div_q;
  reg tick_q;
  reg pending_q;
  reg [3:0] ready_cnt_q;
  reg [`TOR_EV_W-1:0] irq_stat_q, irq_en_q;
  wire both_on, either_off, both_off, both_on_rise, any_off_fall;
  wire blanking, clr_ok, aclr_rise, accept, excite_d;
  wire apb_setup, apb_done, wr_done;
  wire [`TOR_EV_W-1:0] events;
  reg [31:0] rdata_d;
  reg rerr_d;

  // every contact, clear and command is brought onto the clock before use
  tor_sync #(
    .W(`TOR_SYNC_W)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .d({excite_cmd, alarm_clear_in, torque_off_clear_in, shutoff_channel_lower, shutoff_channel_upper}),
    .q(sync_w)
  );

  assign up_on = sync_w[0];
  assign lo_on = sync_w[1];
  assign clr_in = sync_w[2];
  assign aclr_in = sync_w[3];
  assign cmd_in = sync_w[4];

  // channel combinations
  assign both_on = up_on & lo_on;
  assign either_off = ~both_on;
  assign both_off = ~up_on & ~lo_on;
  assign both_on_rise = both_on & ~both_on_prev_q;
  assign any_off_fall = either_off & both_on_prev_q;

  // edge history of the synchronised inputs
  always @(posedge clock) begin
    if (srst) begin
      clr_prev_q <= 1'b0;
      aclr_prev_q <= 1'b0;
      both_on_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= clr_in;
      aclr_prev_q <= aclr_in;
      both_on_prev_q <= both_on;
    end
  end

  // millisecond divider, restarted when blanking loads so the first ms is full length
  always @(posedge clock) begin
    if (srst || both_on_rise) begin
      div_q <= {`TOR_MS_CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else if (div_q == MS_TICK_CYCLES[`TOR_MS_CNT_W-1:0] - 1'b1) begin
      div_q <= {`TOR_MS_CNT_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // blanking counter in ms; loads at the moment both channels are on
  always @(posedge clock) begin
    if (srst || either_off) begin
      blank_cnt_q <= `TOR_BLANK_RESET;
    end else if (both_on_rise) begin
      blank_cnt_q <= blank_ms_q;
    end else if (tick_q && blank_cnt_q != `TOR_BLANK_RESET) begin
      blank_cnt_q <= blank_cnt_q - 1'b1;
    end
  end
  // a zero setting blanks nothing, the clear works in the cycle after both are on
  assign blanking = (blank_cnt_q != `TOR_BLANK_RESET) | both_on_rise;

  // clear qualification: level mode accepts a held clear, anything else acts on the edge
  assign clr_ok = (crit_q == `TOR_CRIT_LEVEL) ? clr_in : (clr_in & ~clr_prev_q);
  assign aclr_rise = aclr_in & ~aclr_prev_q;
  // with alarm mode on, recovery needs the alarm clear edge instead of the torque-off clear
  assign accept = both_on & ~blanking & cmd_in & (alarm_mode_q ? aclr_rise : clr_ok);

  // pending recovery: set by any channel off, dropped only by an accepted clear
  always @(posedge clock) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (either_off) begin
      pending_q <= 1'b1;
    end else if (accept) begin
      pending_q <= 1'b0;
    end
  end

  // excitation needs both channels, the host command and no pending recovery
  assign excite_d = both_on & cmd_in & (~pending_q | accept);

  // motor drive and power removal; both follow the inputs within a few cycles, well inside 10/15 ms
  always @(posedge clock) begin
    if (srst) begin
      motor_excite <= 1'b0;
      power_removed <= 1'b0;
    end else begin
      motor_excite <= excite_d;
      power_removed <= both_off;
    end
  end

  // ready follows excitation after a short settle counted in ms ticks
  always @(posedge clock) begin
    if (srst || !excite_d) begin
      ready_cnt_q <= 4'h0;
      drive_ready <= 1'b0;
    end else if (ready_cnt_q == `TOR_READY_DELAY_MS) begin
      drive_ready <= 1'b1;
    end else if (tick_q) begin
      ready_cnt_q <= ready_cnt_q + 1'b1;
    end
  end

  // monitor outputs
  always @(posedge clock) begin
    if (srst) begin
      shutoff_input_off_monitor <= 1'b0;
      external_device_monitor <= 1'b0;
      torque_off_state_monitor <= 1'b0;
    end else begin
      shutoff_input_off_monitor <= either_off;
      external_device_monitor <= both_off;
      if (either_off && alarm_mode_q == `TOR_MODE_NO_ALARM) begin
        torque_off_state_monitor <= 1'b1;
      end else if (accept) begin
        torque_off_state_monitor <= 1'b0;
      end
    end
  end

  // input-detection alarm; a new off beats a simultaneous clear
  always @(posedge clock) begin
    if (srst) begin
      alarm_active <= 1'b0;
      alarm_code <= `TOR_ALARM_NONE;
    end else if (either_off && alarm_mode_q == `TOR_MODE_ALARM) begin
      alarm_active <= 1'b1;
      alarm_code <= `TOR_ALARM_CODE;
    end else if (accept) begin
      alarm_active <= 1'b0;
      alarm_code <= `TOR_ALARM_NONE;
    end
  end

  // interrupt events, one-cycle each
  assign events[`TOR_EV_INPUT_OFF] = any_off_fall;
  assign events[`TOR_EV_REMOVED] = both_off & ~power_removed;
  assign events[`TOR_EV_EXCITED] = excite_d & ~motor_excite;
  assign events[`TOR_EV_ALARM] = any_off_fall & (alarm_mode_q == `TOR_MODE_ALARM);

  // apb: one wait state; writes act and reads complete at the edge where pready is high
  assign apb_setup = psel & penable & ~pready;
  assign apb_done = psel & penable & pready;
  assign wr_done = apb_done & pwrite & ~pslverr;

  // read mux and address decode
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d = 1'b0;
    case (paddr)
      `TOR_OFF_CTRL: begin
        rdata_d[`TOR_CTRL_MODE_BIT] = alarm_mode_q;
        rdata_d[`TOR_CTRL_CRIT_HI:`TOR_CTRL_CRIT_LO] = crit_q;
      end
      `TOR_OFF_BLANK: begin
        rdata_d[6:0] = blank_ms_q;
      end
      `TOR_OFF_STATUS: begin
        rdata_d[`TOR_ST_INPUT_OFF] = shutoff_input_off_monitor;
        rdata_d[`TOR_ST_TORQUE_OFF] = torque_off_state_monitor;
        rdata_d[`TOR_ST_EXT_DEV] = external_device_monitor;
        rdata_d[`TOR_ST_EXCITED] = motor_excite;
        rdata_d[`TOR_ST_READY] = drive_ready;
        rdata_d[`TOR_ST_ALARM] = alarm_active;
        rdata_d[`TOR_ST_BLANKING] = blanking;
        rdata_d[`TOR_ST_REMOVED] = power_removed;
      end
      `TOR_OFF_ALARM: begin
        rdata_d[7:0] = alarm_code;
      end
      `TOR_OFF_IRQ_STAT: begin
        rdata_d[`TOR_EV_W-1:0] = irq_stat_q;
      end
      `TOR_OFF_IRQ_CLR: begin
        rdata_d = 32'h0000_0000; // write-only, reads zero
      end
      `TOR_OFF_IRQ_EN: begin
        rdata_d[`TOR_EV_W-1:0] = irq_en_q;
      end
      default: begin
        rerr_d = 1'b1;
      end
    endcase
  end

  // bus handshake registers
  always @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & rerr_d;
      if (apb_setup && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // settings; an out-of-range blanking value is held at the maximum
  always @(posedge clock) begin
    if (srst) begin
      alarm_mode_q <= `TOR_MODE_NO_ALARM;
      crit_q <= `TOR_CRIT_EDGE;
      blank_ms_q <= `TOR_BLANK_RESET;
      irq_en_q <= {`TOR_EV_W{1'b0}};
    end else if (wr_done) begin
      if (paddr == `TOR_OFF_CTRL) begin
        alarm_mode_q <= pwdata[`TOR_CTRL_MODE_BIT];
        crit_q <= pwdata[`TOR_CTRL_CRIT_HI:`TOR_CTRL_CRIT_LO];
      end
      if (paddr == `TOR_OFF_BLANK) begin
        blank_ms_q <= (pwdata[31:0] > {25'h0, `TOR_BLANK_MAX}) ? `TOR_BLANK_MAX : pwdata[6:0];
      end
      if (paddr == `TOR_OFF_IRQ_EN) begin
        irq_en_q <= pwdata[`TOR_EV_W-1:0];
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always @(posedge clock) begin
    if (srst) begin
      irq_stat_q <= {`TOR_EV_W{1'b0}};
    end else if (wr_done && paddr == `TOR_OFF_IRQ_CLR) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[`TOR_EV_W-1:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  // level interrupt, one cycle behind the status so it leaves a flip-flop
  always @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule

// ===== dv/tor_checker.sv
// checker for the torque-off recovery block, bound to its top
// assumes only top ports are seen; six cycles cover input sync plus output register
`timescale 1ns/1ps
module tor_checker #(
  parameter MS_TICK_CYCLES = 200000
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // contacts and command
  input wire shutoff_channel_upper,
  input wire shutoff_channel_lower,
  input wire excite_cmd,
  // apb handshake
  input wire psel,
  input wire penable,
  input wire pready,
  // monitors and state
  input wire shutoff_input_off_monitor,
  input wire external_device_monitor,
  input wire motor_excite,
  input wire drive_ready,
  input wire power_removed,
  input wire alarm_active,
  input wire [7:0] alarm_code,
  input wire irq
);
  wire up = shutoff_channel_upper;
  wire lo = shutoff_channel_lower;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_ext_both: assert property ((!up && !lo)[*6] |-> external_device_monitor)
    else $error("external monitor low with both channels off");
  a_ext_single: assert property ((up != lo)[*6] |-> shutoff_input_off_monitor && !external_device_monitor)
    else $error("monitors wrong with one channel off");
  a_inputs_on: assert property ((up && lo)[*6] |-> !shutoff_input_off_monitor && !power_removed)
    else $error("input-off monitor high with both channels on");
  a_removal_time: assert property ((!up && !lo)[*6] |-> power_removed && !motor_excite)
    else $error("power removal late");
  a_cmd_needed: assert property ((!excite_cmd)[*6] |-> !motor_excite)
    else $error("excited without host command");
  a_alarm_code: assert property (alarm_code == (alarm_active ? 8'h68 : 8'h00))
    else $error("alarm code does not follow alarm");
  a_ready_excited: assert property ($rose(drive_ready) |-> motor_excite)
    else $error("ready without excitation");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  c_excite: cover property ($rose(motor_excite));
  c_ready: cover property ($rose(drive_ready));
  c_alarm: cover property ($rose(alarm_active));
  c_irq: cover property ($rose(irq));
endmodule

bind tor_top tor_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_tor_checker (.clock(clock), .srst(srst),
  .shutoff_channel_upper(shutoff_channel_upper), .shutoff_channel_lower(shutoff_channel_lower),
  .excite_cmd(excite_cmd), .psel(psel), .penable(penable), .pready(pready),
  .shutoff_input_off_monitor(shutoff_input_off_monitor), .external_device_monitor(external_device_monitor),
  .motor_excite(motor_excite), .drive_ready(drive_ready), .power_removed(power_removed),
  .alarm_active(alarm_active), .alarm_code(alarm_code), .irq(irq));

// ===== dv/tor_host_model.sv
// host model: raises the excitation command a fixed latency after the bench asks
// assumes the request is driven synchronously to clock
`timescale 1ns/1ps
module tor_host_model #(
  parameter int LAT = 2
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // request in, command out
  input wire want,
  output logic excite_cmd
);
  logic [LAT-1:0] pipe_q;
  // fieldbus delay; a larger LAT models a slow host
  always @(posedge clock) begin
    if (srst) begin
      pipe_q <= '0;
      excite_cmd <= 1'b0;
    end else begin
      pipe_q <= {pipe_q[LAT-2:0], want};
      excite_cmd <= pipe_q[LAT-1];
    end
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the torque-off recovery block
// assumes a 200 MHz clock and a 20-cycle millisecond tick
`timescale 1ns/1ps
`include "tor_map.vh"
module tb_top;
  logic clock = 0, srst = 1, up = 1, lo = 1, clr = 0, aclr = 0, want = 1;
  logic psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire [7:0] acode;
  wire pready, pslverr, cmd, iom, tom, edm, mex, rdy, prm, alm, irq;
  int errors = 0, n_tests = 0;
  tor_host_model u_tor_host_model (.clock(clock), .srst(srst), .want(want), .excite_cmd(cmd));
  tor_top #(.MS_TICK_CYCLES(20)) u_tor_top (.clock(clock), .srst(srst), .shutoff_channel_upper(up),
    .shutoff_channel_lower(lo), .torque_off_clear_in(clr), .alarm_clear_in(aclr), .excite_cmd(cmd),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shutoff_input_off_monitor(iom), .torque_off_state_monitor(tom),
    .external_device_monitor(edm), .motor_excite(mex), .drive_ready(rdy), .power_removed(prm),
    .alarm_active(alm), .alarm_code(acode), .irq(irq));
  // free-running clock
  initial forever #2.5 clock = ~clock;
  task end_sim;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    // a timeout ends the run, so nothing of the transfer may follow it
    if (k >= 20) begin
      errors++;
      end_sim();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  // contacts change, then let sync and outputs settle
  task chan(input logic u, input logic l);
    up <= u;
    lo <= l;
    wt(8);
  endtask
  task pclr;
    clr <= 1'b1;
    wt(3);
    clr <= 1'b0;
    wt(3);
  endtask
  initial begin
    wt(12);
    srst <= 1'b0;
    wt(4);
    apb(0, `TOR_OFF_CTRL, 0);
    chk("ctrl", rd, 32'h2);
    apb(0, `TOR_OFF_BLANK, 0);
    chk("blank", rd, 32'h0);
    apb(0, 12'h020, 0);
    chk("slverr", {31'h0, err}, 32'h1);
    // reset looks like an off event, so a clear is needed
    wt(40);
    chk("tom", {31'h0, tom}, 32'h1);
    chk("mex", {31'h0, mex}, 32'h0);
    pclr();
    wt(190);
    chk("mex", {31'h0, mex}, 32'h1);
    chk("tom", {31'h0, tom}, 32'h0);
    // looked at about 10 ms after the clear, well inside the 60 ms ready limit
    chk("rdy", {31'h0, rdy}, 32'h1);
    want <= 1'b0;
    wt(12);
    chk("mex", {31'h0, mex}, 32'h0);
    want <= 1'b1;
    wt(12);
    // one channel off raises an enabled interrupt, but no alarm in mode 0
    apb(1, `TOR_OFF_IRQ_EN, 32'h1);
    chan(0, 1);
    chk("iom", {31'h0, iom}, 32'h1);
    chk("edm", {31'h0, edm}, 32'h0);
    chk("mex", {31'h0, mex}, 32'h0);
    chk("alm", {31'h0, alm}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(0, `TOR_OFF_IRQ_STAT, 0);
    chk("irq_st", rd & 32'h1, 32'h1);
    apb(1, `TOR_OFF_IRQ_CLR, 32'h1);
    wt(2);
    chk("irq", {31'h0, irq}, 32'h0);
    chan(0, 0);
    chk("edm", {31'h0, edm}, 32'h1);
    chk("prm", {31'h0, prm}, 32'h1);
    apb(1, `TOR_OFF_BLANK, 32'h7f);
    apb(0, `TOR_OFF_BLANK, 0);
    chk("clamp", rd, 32'h64);
    apb(1, `TOR_OFF_BLANK, 32'h5);
    // clear inside the 100-cycle blanking is ignored
    chan(1, 1);
    chk("iom", {31'h0, iom}, 32'h0);
    // status shows torque-off still set and blanking running
    apb(0, `TOR_OFF_STATUS, 0);
    chk("status", rd, 32'h42);
    pclr();
    wt(200);
    chk("mex", {31'h0, mex}, 32'h0);
    pclr();
    wt(200);
    chk("mex", {31'h0, mex}, 32'h1);
    // level mode: a held clear excites once blanking ends
    apb(1, `TOR_OFF_CTRL, 32'h4);
    chan(0, 0);
    clr <= 1'b1;
    chan(1, 1);
    wt(50);
    chk("mex", {31'h0, mex}, 32'h0);
    wt(250);
    chk("mex", {31'h0, mex}, 32'h1);
    clr <= 1'b0;
    // alarm mode with recovery by the alarm clear edge
    apb(1, `TOR_OFF_CTRL, 32'h3);
    apb(1, `TOR_OFF_BLANK, 32'h0);
    chan(0, 1);
    chk("alm", {31'h0, alm}, 32'h1);
    chk("tom", {31'h0, tom}, 32'h0);
    apb(0, `TOR_OFF_ALARM, 0);
    chk("code", rd, 32'h68);
    chan(1, 1);
    aclr <= 1'b1;
    wt(3);
    aclr <= 1'b0;
    wt(200);
    chk("alm", {31'h0, alm}, 32'h0);
    chk("mex", {31'h0, mex}, 32'h1);
    end_sim();
  end
endmodule
